// *** core/onsw_ctrl.sv ***
// on/off switcher control sequencer top
`timescale 1ns/1ps
`include "onsw_regs.svh"
module onsw_ctrl #(
  parameter int AR_ON_OSC = `ONSW_AR_ON_OSC,
  parameter int AR_OFF_OSC = `ONSW_AR_OFF_OSC,
  parameter int LEB_CYC = `ONSW_LEB_CYC,
  parameter int ILIM_WIN = 16,
  parameter int ILIM_UP_THR = 12,
  parameter int ILIM_DN_THR = 4
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // enable_line_sense_input comparators
  input wire logic i_en_pull_over_thr,
  input wire logic i_line_sense_ok,
  input wire logic i_no_line_resistor,
  // bypass_supply_node comparators
  input wire logic i_bypass_below_lo,
  input wire logic i_bypass_above_hi,
  // thermal comparators
  input wire logic i_temp_hot,
  input wire logic i_temp_cooled,
  // switch current comparator against the active limit
  input wire logic i_cur_over_limit,
  // power switch
  output logic o_gate_on,
  // current limit level, 3 is highest
  output onsw_pkg::onsw_lvl_t o_ilimit_level,
  // status
  output logic o_bypass_hold_low,
  output logic o_autorestart_off,
  output logic o_thermal_off,
  output logic o_bypass_uv,
  output logic o_ext_allowed
);
  import onsw_pkg::*;

  onsw_osc_if osc_bus ();

  onsw_osc #(
    .PER_MIN(`ONSW_PER_MIN_CYC),
    .SPAN(`ONSW_JIT_SPAN),
    .STEP(`ONSW_JIT_STEP_CYC),
    .DUTY(`ONSW_DUTY_CYC)
  ) u_osc (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .osc(osc_bus.osc)
  );

  onsw_state_t state_r;
  onsw_lvl_t lvl_r;
  logic en_out_r;
  logic en_sample_r;
  logic bp_uv_r;
  logic hot_r;
  logic ext_ok_r;
  logic gate_r;
  logic extending_r;
  logic [7:0] blank_r;
  logic [23:0] ar_cnt_r;
  logic [7:0] win_cnt_r;
  logic [7:0] en_cnt_r;
  logic line_uv;
  logic allowed;
  logic cyc;
  logic turn_on;
  logic cl_trip;
  logic duty_end;
  logic ar_clear;
  logic ar_expire;

  assign cyc = osc_bus.cycle_start;

  // a missing sense resistor looks like near-zero line current; gating is
  // dropped so a resistor-less design can still start
  assign line_uv = !i_no_line_resistor && !i_line_sense_ok;

  // switching needs the run state and both supply and thermal guards clear
  assign allowed = (state_r == ST_RUN) && !bp_uv_r && !hot_r;

  // the enable circuit output is low while the pull exceeds the threshold
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      en_out_r <= 1'b1;
    end else begin
      en_out_r <= !i_en_pull_over_thr;
    end
  end

  // only the cycle-start sample counts; mid-cycle changes never reach the gate
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      en_sample_r <= 1'b0;
    end else if (cyc) begin
      en_sample_r <= en_out_r;
    end
  end

  // the cycle that runs the restart timer out hands over without a pulse, so
  // the off phase never opens with a one-clock stub on the gate
  assign ar_expire = (state_r == ST_RUN) && cyc && en_out_r
    && (ar_cnt_r >= 24'(AR_ON_OSC - 1));

  // an enabled cycle is one whose sample is high and switching is allowed
  assign turn_on = cyc && en_out_r && allowed && !ar_expire;

  // bypass undervoltage hysteresis, held until the supply first reaches the
  // upper level after reset
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      bp_uv_r <= 1'b1;
    end else if (i_bypass_below_lo) begin
      bp_uv_r <= 1'b1;
    end else if (i_bypass_above_hi) begin
      bp_uv_r <= 1'b0;
    end
  end

  // thermal shutdown with wide hysteresis to keep a faulted board cool
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      hot_r <= 1'b0;
    end else if (i_temp_hot) begin
      hot_r <= 1'b1;
    end else if (i_temp_cooled) begin
      hot_r <= 1'b0;
    end
  end

  // extension stays off until the feedback first pulls enable low
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ext_ok_r <= 1'b0;
    end else if (cyc && !en_out_r) begin
      ext_ok_r <= 1'b1;
    end
  end

  // blanking counter restarts at each turn-on
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      blank_r <= 8'h0;
    end else if (turn_on) begin
      blank_r <= 8'(LEB_CYC);
    end else if (blank_r != 8'h0) begin
      blank_r <= blank_r - 8'h1;
    end
  end

  // the limit comparator is masked while blanking runs
  assign cl_trip = i_cur_over_limit && (blank_r == 8'h0);

  // end of the max duty window; with extension the pulse runs on to the limit
  assign duty_end = !osc_bus.max_duty_signal && !ext_ok_r;

  // power switch gate
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      gate_r <= 1'b0;
    end else if (turn_on) begin
      gate_r <= 1'b1;
    end else if (cyc || !allowed) begin
      // a new cycle re-decides; an extended pulse still on at an enabled cycle start runs on into it
      gate_r <= 1'b0;
    end else if (gate_r && !en_sample_r) begin
      // no pulse outlives a cycle whose start sample was low
      gate_r <= 1'b0;
    end else if (gate_r && (cl_trip || duty_end)) begin
      gate_r <= 1'b0;
    end
  end

  // marks a pulse that has run past the max duty window
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      extending_r <= 1'b0;
    end else begin
      extending_r <= gate_r && !osc_bus.max_duty_signal && ext_ok_r;
    end
  end

  // in the run state the counter clears on every cycle the feedback pulls enable low
  assign ar_clear = cyc && !en_out_r;

  // power sequencing and auto-restart
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= ST_STARTUP;
      ar_cnt_r <= 24'h0;
    end else begin
      unique case (state_r)
        ST_STARTUP: begin
          ar_cnt_r <= 24'h0;
          // start needs a charged bypass and line sense above threshold
          if (!bp_uv_r && !line_uv) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (ar_clear) begin
            ar_cnt_r <= 24'h0;
          end else if (cyc) begin
            if (ar_cnt_r >= 24'(AR_ON_OSC - 1)) begin
              // lost regulation too long: a fault or a falling line
              ar_cnt_r <= 24'h0;
              state_r <= ST_AR_OFF;
            end else begin
              ar_cnt_r <= ar_cnt_r + 24'h1;
            end
          end
        end
        ST_AR_OFF: begin
          // low line freezes the off timer so a dying supply never restarts
          if (cyc && !line_uv) begin
            if (ar_cnt_r >= 24'(AR_OFF_OSC - 1)) begin
              ar_cnt_r <= 24'h0;
              state_r <= ST_RUN;
            end else begin
              ar_cnt_r <= ar_cnt_r + 24'h1;
            end
          end
        end
        default: begin
          // an unused state code falls back to a clean start
          state_r <= ST_STARTUP;
          ar_cnt_r <= 24'h0;
        end
      endcase
    end
  end

  // load inference: count enabled cycles in a fixed window of oscillator cycles
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      win_cnt_r <= 8'h0;
      en_cnt_r <= 8'h0;
    end else if (cyc) begin
      if (win_cnt_r == 8'(ILIM_WIN - 1)) begin
        win_cnt_r <= 8'h0;
        en_cnt_r <= 8'h0;
      end else begin
        win_cnt_r <= win_cnt_r + 8'h1;
        if (turn_on) en_cnt_r <= en_cnt_r + 8'h1;
      end
    end
  end

  // one level per window keeps the step audible-noise friendly and stable;
  // the last cycle of a window is judged on the count before it
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      lvl_r <= LVL_TOP;
    end else if (cyc && win_cnt_r == 8'(ILIM_WIN - 1)) begin
      if (en_cnt_r >= 8'(ILIM_UP_THR) && lvl_r != LVL_TOP) begin
        lvl_r <= lvl_r + 2'h1;
      end else if (en_cnt_r < 8'(ILIM_DN_THR) && lvl_r != 2'h0) begin
        lvl_r <= lvl_r - 2'h1;
      end
    end
  end

  // registered outputs
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_gate_on <= 1'b0;
      o_ilimit_level <= LVL_TOP;
      o_bypass_hold_low <= 1'b0;
      o_autorestart_off <= 1'b0;
      o_thermal_off <= 1'b0;
      o_bypass_uv <= 1'b1;
      o_ext_allowed <= 1'b0;
    end else begin
      o_gate_on <= gate_r;
      o_ilimit_level <= lvl_r;
      o_bypass_hold_low <= (state_r == ST_STARTUP) && line_uv;
      o_autorestart_off <= (state_r == ST_AR_OFF);
      o_thermal_off <= hot_r;
      o_bypass_uv <= bp_uv_r;
      o_ext_allowed <= ext_ok_r || extending_r;
    end
  end
endmodule

// *** core/onsw_osc.sv ***
// jittered switching oscillator
`timescale 1ns/1ps
`include "onsw_regs.svh"
module onsw_osc #(
  parameter int PER_MIN = `ONSW_PER_MIN_CYC,
  parameter int SPAN = `ONSW_JIT_SPAN,
  parameter int STEP = `ONSW_JIT_STEP_CYC,
  parameter int DUTY = `ONSW_DUTY_CYC
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // timing out
  onsw_osc_if.osc osc
);
  import onsw_pkg::*;
  logic [7:0] phase_r;
  logic [7:0] tri_r;
  logic tri_up_r;
  logic [15:0] step_r;
  logic [7:0] period;

  // triangle offset sweeps the period between min and max once per modulation
  assign period = 8'(PER_MIN) + tri_r;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      step_r <= 16'h0;
      tri_r <= 8'h0;
      tri_up_r <= 1'b1;
    end else if (step_r == 16'(STEP - 1)) begin
      step_r <= 16'h0;
      if (tri_up_r) begin
        tri_r <= tri_r + 8'h1;
        if (tri_r == 8'(SPAN - 1)) tri_up_r <= 1'b0;
      end else begin
        tri_r <= tri_r - 8'h1;
        if (tri_r == 8'h1) tri_up_r <= 1'b1;
      end
    end else begin
      step_r <= step_r + 16'h1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      phase_r <= 8'h0;
      osc.cycle_start <= 1'b0;
      osc.max_duty_signal <= 1'b0;
    end else begin
      phase_r <= (phase_r >= period - 8'h1) ? 8'h0 : phase_r + 8'h1;
      osc.cycle_start <= (phase_r == 8'h0);
      osc.max_duty_signal <= (phase_r < 8'(DUTY));
    end
  end
endmodule

// *** core/onsw_osc_if.sv ***
// oscillator to sequencer timing signals
`timescale 1ns/1ps
interface onsw_osc_if;
  logic cycle_start;
  logic max_duty_signal;
  modport osc (output cycle_start, output max_duty_signal);
  modport ctl (input cycle_start, input max_duty_signal);
endinterface

// *** core/onsw_pkg.sv ***
// types shared by the switcher control sequencer
package onsw_pkg;
  typedef enum logic [1:0] {ST_STARTUP, ST_RUN, ST_AR_OFF} onsw_state_t;
  typedef logic [1:0] onsw_lvl_t;
  localparam onsw_lvl_t LVL_TOP = 2'h3;
endpackage

// *** core/onsw_regs.svh ***
// constants for the on/off switcher control sequencer
// Summary of operation
// - oscillator averaging 132 kHz gives cycle-start clock and max duty signal.
// - oscillator frequency jitters 8 kHz peak-to-peak, modulation repeating at 1 kHz.
// - enable output is low while enable pin current exceeds its threshold.
// - enable output sampled at cycle start; high turns switch on, low skips cycle.
// - after sampling, enable changes are ignored until next cycle start.
// - current limit level lowered at medium/light load, restored at heavy load.
// - bypass below 4.9 V stops switching until it recovers to 5.85 V.
// - over-temperature stops switching until die cools by 75 C.
// - switch current above active limit ends the pulse for this cycle.
// - current limit ignored for a blanking time after each turn-on.
// - auto-restart counter, clocked by oscillator, clears when enable pulled low.
// - no enable pull-low for 64 ms stops switching 2.5 s, then repeats.
// - during auto-restart off with line undervoltage the counter is frozen.
// - with extension active the switch stays on past max duty until limit.
// - extension suppressed at startup until first regulation indication.
// - power up or auto-restart off waits for line sense above 25 uA.
// - at power up with line undervoltage bypass held at 4.9 V.
// - no line sense resistor fitted disables line undervoltage gating.
// - enabled cycle turns on at start, off at current limit or max duty.
// - at power down switching lasts 64 ms, then stays off while line low.
`ifndef ONSW_REGS_SVH
`define ONSW_REGS_SVH
`define ONSW_CLK_HZ 20000000
`define ONSW_OSC_HZ 132000
`define ONSW_JIT_PP_HZ 8000
`define ONSW_JIT_RATE_HZ 1000
`define ONSW_DUTY_PCT 65
`define ONSW_AR_ON_MS 64
`define ONSW_AR_OFF_MS 2500
`define ONSW_LEB_NS 200
`define ONSW_PER_NOM_CYC (`ONSW_CLK_HZ / `ONSW_OSC_HZ)
`define ONSW_PER_MIN_CYC (`ONSW_CLK_HZ / (`ONSW_OSC_HZ + `ONSW_JIT_PP_HZ / 2))
`define ONSW_PER_MAX_CYC (`ONSW_CLK_HZ / (`ONSW_OSC_HZ - `ONSW_JIT_PP_HZ / 2))
`define ONSW_JIT_SPAN (`ONSW_PER_MAX_CYC - `ONSW_PER_MIN_CYC)
`define ONSW_JIT_STEP_CYC (`ONSW_CLK_HZ / (`ONSW_JIT_RATE_HZ * 2 * `ONSW_JIT_SPAN))
`define ONSW_DUTY_CYC (`ONSW_PER_NOM_CYC * `ONSW_DUTY_PCT / 100)
`define ONSW_LEB_CYC ((`ONSW_LEB_NS * (`ONSW_CLK_HZ / 1000000) + 999) / 1000)
`define ONSW_AR_ON_OSC (`ONSW_AR_ON_MS * (`ONSW_OSC_HZ / 1000))
`define ONSW_AR_OFF_OSC (`ONSW_AR_OFF_MS * (`ONSW_OSC_HZ / 1000))
`endif

// *** dv/onsw_monitor.sv ***
// bound checker for the switcher control sequencer
`timescale 1ns/1ps
module onsw_monitor (
  // clock, reset and comparators
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_temp_hot,
  input wire logic i_temp_cooled,
  input wire logic i_bypass_below_lo,
  input wire logic i_bypass_above_hi,
  input wire logic i_cur_over_limit,
  // watched outputs
  input wire logic o_gate_on,
  input wire onsw_pkg::onsw_lvl_t o_ilimit_level,
  input wire logic o_autorestart_off,
  input wire logic o_thermal_off,
  input wire logic o_bypass_uv,
  input wire logic o_ext_allowed
);
  import onsw_pkg::*;
  logic [7:0] on_r;
  logic [7:0] gap_r;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) on_r <= 8'h00;
    else on_r <= o_gate_on ? on_r + 8'h01 : 8'h00;
  end
  // saturates so a long skip run never wraps into a false short period
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) gap_r <= 8'hFF;
    else if (o_gate_on && on_r == 8'h00) gap_r <= 8'h01;
    else if (gap_r != 8'hFF) gap_r <= gap_r + 8'h01;
  end
  sequence s_long_on; o_gate_on [*6] ##0 i_cur_over_limit; endsequence
  sequence s_locked; (o_thermal_off || o_bypass_uv || o_autorestart_off) [*3]; endsequence
  property p_reset; $rose(i_rstn) |-> o_ilimit_level == LVL_TOP && !o_gate_on && o_bypass_uv;
  endproperty
  property p_limit; s_long_on |-> ##[1:2] !o_gate_on; endproperty
  property p_blank; $rose(o_gate_on) && i_cur_over_limit |=> o_gate_on [*2]; endproperty
  property p_duty; !o_ext_allowed |-> on_r <= 8'h64; endproperty
  property p_ext; o_ext_allowed && o_gate_on && on_r == 8'h64 && !i_cur_over_limit
    && !i_temp_hot && !i_bypass_below_lo |=> o_gate_on; endproperty
  // the status flag trails the comparator by two clocks, hence the look one sample back
  property p_therm; $past(i_temp_hot) || o_thermal_off && !$past(i_temp_cooled)
    |=> o_thermal_off; endproperty
  property p_bypass; $past(i_bypass_below_lo) || o_bypass_uv && !$past(i_bypass_above_hi)
    |=> o_bypass_uv; endproperty
  property p_off; s_locked |-> !o_gate_on; endproperty
  property p_period; o_gate_on && on_r == 8'h00 |-> gap_r >= 8'h92; endproperty
  a_reset: assert property (p_reset) else $error("bad state after reset");
  a_limit: assert property (p_limit) else $error("pulse outlived limit");
  a_blank: assert property (p_blank) else $error("spike ended pulse");
  a_duty: assert property (p_duty) else $error("pulse past max duty");
  a_ext: assert property (p_ext) else $error("extension cut short");
  a_therm: assert property (p_therm) else $error("thermal hold lost");
  a_bypass: assert property (p_bypass) else $error("bypass hold lost");
  a_off: assert property (p_off) else $error("switching while locked");
  a_period: assert property (p_period) else $error("cycle too short");
endmodule

bind onsw_ctrl onsw_monitor u_onsw_monitor (.i_clock, .i_rstn, .i_temp_hot, .i_temp_cooled,
  .i_bypass_below_lo, .i_bypass_above_hi, .i_cur_over_limit, .o_gate_on, .o_ilimit_level,
  .o_autorestart_off, .o_thermal_off, .o_bypass_uv, .o_ext_allowed);

// *** dv/onsw_plant.sv ***
// feedback and power stage model facing the sequencer
`timescale 1ns/1ps
module onsw_plant (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // switch state and bench controls
  input wire logic i_gate_on,
  input wire logic i_demand,
  input wire logic i_spike,
  input wire logic [7:0] i_ramp,
  // toward the sequencer
  output logic o_en_pull_over_thr,
  output logic o_cur_over_limit
);
  logic [7:0] t_r;
  // optocoupler conducts once the output is above its reference
  assign o_en_pull_over_thr = !i_demand;
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) t_r <= 8'h00;
    else t_r <= i_gate_on ? t_r + 8'h01 : 8'h00;
  end
  // current ramps from zero each pulse; spike mimics rectifier recovery at turn-on
  assign o_cur_over_limit = i_gate_on && (t_r >= i_ramp || i_spike && t_r < 8'h02);
endmodule

// *** dv/onsw_tb.sv ***
// self-checking bench for the switcher control sequencer
`timescale 1ns/1ps
module testbench;
  import onsw_pkg::*;
  typedef struct {int lo; int hi;} onsw_win_t;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic i_temp_hot = 1'b0;
  logic i_temp_cooled = 1'b0;
  logic i_bypass_below_lo = 1'b0;
  logic i_bypass_above_hi = 1'b1;
  logic i_line_sense_ok = 1'b0;
  logic i_no_line_resistor = 1'b1;
  logic demand = 1'b1;
  logic spike = 1'b0;
  logic strict = 1'b0;
  logic [7:0] ramp = 8'h78;
  logic [7:0] r;
  logic [15:0] seed = 16'hD0B2;
  wire i_en_pull_over_thr, i_cur_over_limit, o_gate_on, o_bypass_hold_low;
  wire o_autorestart_off, o_thermal_off, o_bypass_uv, o_ext_allowed;
  onsw_lvl_t o_ilimit_level;
  onsw_win_t q[$];
  onsw_win_t win;
  int n_errors = 0;
  int cmp_count = 0;
  int w = 0;
  onsw_ctrl #(.AR_ON_OSC(8), .AR_OFF_OSC(20)) u_onsw_ctrl (.i_clock, .i_rstn,
    .i_en_pull_over_thr, .i_line_sense_ok, .i_no_line_resistor, .i_bypass_below_lo,
    .i_bypass_above_hi, .i_temp_hot, .i_temp_cooled, .i_cur_over_limit, .o_gate_on,
    .o_ilimit_level, .o_bypass_hold_low, .o_autorestart_off, .o_thermal_off, .o_bypass_uv,
    .o_ext_allowed);
  onsw_plant u_onsw_plant (.i_clock, .i_rstn, .i_gate_on(o_gate_on), .i_demand(demand),
    .i_spike(spike), .i_ramp(ramp), .o_en_pull_over_thr(i_en_pull_over_thr),
    .o_cur_over_limit(i_cur_over_limit));
  always #25 i_clock = ~i_clock;
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed;
  endfunction
  // n pulses of ramp length rr, then feedback pulls low so the run stops cleanly
  task automatic run(input int n, input logic [7:0] rr, input int lo, input int hi);
    for (int k = 0; k < n; k++) q.push_back('{lo, hi});
    ramp <= rr;
    demand <= 1'b1;
    for (int k = 0; k < n * 200 + 400 && q.size() > 0; k++) @(posedge i_clock);
    demand <= 1'b0;
    chk("pulses missing", 8'h00, 8'(q.size()));
    q.delete();
    repeat (400) @(posedge i_clock);
  endtask
  task automatic lockout(input logic th);
    if (th) i_temp_hot <= 1'b1;
    else begin
      i_bypass_below_lo <= 1'b1;
      i_bypass_above_hi <= 1'b0;
    end
    repeat (3) @(posedge i_clock);
    i_temp_hot <= 1'b0;
    i_bypass_below_lo <= 1'b0;
    demand <= 1'b1;
    repeat (600) @(posedge i_clock);
    chk("lockout held", 8'h01, 8'(th ? o_thermal_off : o_bypass_uv));
    demand <= 1'b0;
    i_temp_cooled <= th;
    i_bypass_above_hi <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_temp_cooled <= 1'b0;
    chk("lockout released", 8'h00, 8'(th ? o_thermal_off : o_bypass_uv));
    run(2, 8'h28, 40, 43);
  endtask
  task automatic wait_ar(input logic v, input int lim);
    for (int k = 0; k < lim && o_autorestart_off !== v; k++) @(posedge i_clock);
  endtask
  // scoreboard: each finished pulse takes the oldest expected width window
  always @(posedge i_clock) begin
    if (o_gate_on === 1'b1) w++;
    else if (w > 0) begin
      if (q.size() > 0) begin
        win = q.pop_front();
        chk("pulse width", 8'h01, 8'(w >= win.lo && w <= win.hi));
      end else if (strict) chk("stray pulse", 8'h00, 8'h01);
      w = 0;
    end
  end
  initial begin
    repeat (5) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    chk("limit level", 8'(LVL_TOP), 8'(o_ilimit_level));
    chk("extension", 8'h00, 8'(o_ext_allowed));
    run(3, 8'h78, 95, 101);
    strict = 1'b1;
    chk("extension", 8'h01, 8'(o_ext_allowed));
    run(3, 8'h78, 120, 123);
    repeat (4) begin
      r = 8'h0A + 8'(rnd() % 16'h003C);
      run(1 + int'(rnd() % 16'h0004), r, r, r + 3);
    end
    spike <= 1'b1;
    run(2, 8'h1E, 30, 33);
    spike <= 1'b0;
    repeat (2600) @(posedge i_clock);
    chk("light load level", 8'h01, 8'(o_ilimit_level < LVL_TOP));
    lockout(1'b1);
    lockout(1'b0);
    strict = 1'b0;
    demand <= 1'b1;
    wait_ar(1'b1, 2500);
    chk("restart off", 8'h01, 8'(o_autorestart_off));
    repeat (5) @(posedge i_clock);
    strict = 1'b1;
    i_no_line_resistor <= 1'b0;
    repeat (4000) @(posedge i_clock);
    chk("off frozen", 8'h01, 8'(o_autorestart_off));
    strict = 1'b0;
    i_line_sense_ok <= 1'b1;
    wait_ar(1'b0, 4000);
    chk("restart on", 8'h00, 8'(o_autorestart_off));
    demand <= 1'b0;
    repeat (400) @(posedge i_clock);
    // second power-up with a sense resistor fitted and the line still low
    i_line_sense_ok <= 1'b0;
    i_rstn <= 1'b0;
    repeat (5) @(posedge i_clock);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clock);
    chk("bypass held low", 8'h01, 8'(o_bypass_hold_low));
    chk("extension", 8'h00, 8'(o_ext_allowed));
    chk("restart off", 8'h00, 8'(o_autorestart_off));
    i_line_sense_ok <= 1'b1;
    repeat (3) @(posedge i_clock);
    chk("bypass released", 8'h00, 8'(o_bypass_hold_low));
    run(2, 8'h28, 40, 43);
    conclude();
  end
  initial begin
    #(60000 * 50);
    n_errors++;
    conclude();
  end
endmodule
